// ==== rtl/pmca_cfg.svh ====
// Purpose: Constants for the power mode and control access block
// Assumes: 200 MHz device clock
// Notes:   Times are given in their own unit; cycle counts derive from them
`ifndef PMCA_CFG_SVH
`define PMCA_CFG_SVH
`define PMCA_CLK_MHZ          200
`define PMCA_SHDN_RAMP_MS     25
`define PMCA_SLEEP_RAMP_MS    25
`define PMCA_WAKE_MS          1
`define PMCA_SHDN_RAMP_CYC    (`PMCA_SHDN_RAMP_MS * `PMCA_CLK_MHZ * 1000)
`define PMCA_SLEEP_RAMP_CYC   (`PMCA_SLEEP_RAMP_MS * `PMCA_CLK_MHZ * 1000)
`define PMCA_WAKE_CYC         (`PMCA_WAKE_MS * `PMCA_CLK_MHZ * 1000)
`define PMCA_PAGE_REGS        128
`define PMCA_PAGE_SLOTS       4
`define PMCA_REG_PAGE         7'h00
`define PMCA_REG_SOFT_RESET   7'h01
`define PMCA_REG_MODE         7'h02
`define PMCA_REG_SHDN_CFG     7'h05
`define PMCA_REG_INPUT_CHANNEL_ENABLES     7'h73
`define PMCA_REG_OUT_CH_EN    7'h74
`define PMCA_REG_POWER_UP_CONFIG      7'h75
`define PMCA_REG_STATUS0      7'h76
`define PMCA_REG_STATUS1      7'h77
`define PMCA_BIT_SOFT_RESET   0
`define PMCA_BIT_SLEEP_EXIT   0
`define PMCA_BIT_BCAST        2
`define PMCA_BIT_ANALOG_REGULATOR_RAIL_SEL     7
`define PMCA_SHDN_CFG_LSB     2
`define PMCA_SHDN_CFG_DEFAULT 8'h04
`define PMCA_PAGE_CFG         8'h00
`define PMCA_PAGE_COEF_FIRST  8'h02
`define PMCA_PAGE_COEF_LAST   8'h04
`define PMCA_ADDR_FIXED       5'h13
`define PMCA_ADDR_BCAST       7'h4C
`define PMCA_STS1_SLEEP       8'h80
`define PMCA_STS1_ACTIVE      8'hC0
`endif

// ==== rtl/pmca_pkg.sv ====
// Purpose: Types for the power mode and control access block
// Assumes: Constants come from pmca_cfg.svh
// Notes:   States use Gray codes along the usual path
package pmca_pkg;
   typedef enum logic [2:0] {
      PMCA_HW_SHDN    = 3'h0,
      PMCA_LOAD_DEF   = 3'h1,
      PMCA_SLEEP      = 3'h3,
      PMCA_WAKE       = 3'h2,
      PMCA_ACTIVE     = 3'h6,
      PMCA_RAMP_SLEEP = 3'h7,
      PMCA_RAMP_SHDN  = 3'h5
   } pmca_mode_e;
   typedef logic [7:0] pmca_byte_t;
endpackage

// ==== rtl/pmca_if.sv ====
// Purpose: Carrier between the mode sequencer and the paged register file
// Assumes: Single clock domain
// Notes:   Read data is combinational; the sequencer registers it
`timescale 1ns/1ps
interface pmca_if;
   import pmca_pkg::*;
   logic       wr;
   logic [6:0] addr;
   pmca_byte_t wdata;
   pmca_byte_t rdata;
   logic       clear;
   logic       soft_reset_req;
   logic       sleep_exit;
   logic       bcast_en;
   logic       analog_regulator_rail_sel;
   logic [1:0] shdn_cfg;
   pmca_byte_t page;
   pmca_byte_t input_channel_enables;
   pmca_byte_t status0;
   pmca_byte_t status1;
   modport seq  (output wr, addr, wdata, clear, status0, status1,
                 input rdata, soft_reset_req, sleep_exit, bcast_en, analog_regulator_rail_sel, shdn_cfg, page, input_channel_enables);
   modport regs (input wr, addr, wdata, clear, status0, status1,
                 output rdata, soft_reset_req, sleep_exit, bcast_en, analog_regulator_rail_sel, shdn_cfg, page, input_channel_enables);
endinterface

// ==== rtl/pmca_regs.sv ====
// Purpose: Paged 8-bit control register file with coefficient pages
// Assumes: Writes arrive as one-cycle strobes from the sequencer
// Notes:   Unmapped pages read zero and ignore writes, except register 0, the page selector
`timescale 1ns/1ps
`include "pmca_cfg.svh"
module pmca_regs
   import pmca_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   pmca_if.regs     bus
);
   pmca_byte_t mem_ff [0:`PMCA_PAGE_SLOTS*`PMCA_PAGE_REGS-1];
   pmca_byte_t page_ff;
   logic       slot_ok;
   logic [1:0] slot;
   logic [8:0] idx;
   logic [2:0] slot_code;

   // Page 0 sits in slot 0, coefficient pages 2..4 in slots 1..3
   function automatic logic [2:0] page_slot(input pmca_byte_t p);
      if (p == `PMCA_PAGE_CFG)
         return 3'h4;
      if (p >= `PMCA_PAGE_COEF_FIRST && p <= `PMCA_PAGE_COEF_LAST)
         return {1'b1, 2'(p - 8'h01)};
      return 3'h0;
   endfunction

   function automatic pmca_byte_t reg_default(input int i);
      return (i == int'(`PMCA_REG_SHDN_CFG)) ? `PMCA_SHDN_CFG_DEFAULT : 8'h00;
   endfunction

   // Function result is held in a wire, as a select on a call is not portable
   assign slot_code = page_slot(page_ff);
   assign slot_ok   = slot_code[2];
   assign slot      = slot_code[1:0];
   assign idx     = {slot, bus.addr};

   wire is_page   = bus.addr == `PMCA_REG_PAGE;
   wire is_sreset = (page_ff == `PMCA_PAGE_CFG) && (bus.addr == `PMCA_REG_SOFT_RESET);
   wire is_sts    = (page_ff == `PMCA_PAGE_CFG) &&
                    (bus.addr == `PMCA_REG_STATUS0 || bus.addr == `PMCA_REG_STATUS1);
   wire mem_we    = bus.wr && slot_ok && !is_page && !is_sreset && !is_sts;

   // Soft reset bit is never stored, so it reads back as zero
   assign bus.soft_reset_req = bus.wr && is_sreset && bus.wdata[`PMCA_BIT_SOFT_RESET]; // RULE11 RULE20

   always_ff @(posedge clk) begin
      if (!reset_n || bus.clear) begin
         page_ff <= `PMCA_PAGE_CFG; // RULE13
      end else if (bus.wr && is_page) begin
         page_ff <= bus.wdata; // RULE14
      end
   end

   // Held clear in shutdown, so contents are lost there
   always_ff @(posedge clk) begin
      if (!reset_n || bus.clear) begin
         for (int i = 0; i < `PMCA_PAGE_SLOTS*`PMCA_PAGE_REGS; i++) begin
            mem_ff[i] <= reg_default(i); // RULE1 RULE5 RULE11
         end
      end else if (mem_we) begin
         mem_ff[idx] <= bus.wdata; // RULE12
      end
   end

   assign bus.rdata = is_page ? page_ff :
                      (is_sts && bus.addr == `PMCA_REG_STATUS0) ? bus.status0 :
                      is_sts ? bus.status1 :
                      (slot_ok && !is_sreset) ? mem_ff[idx] : 8'h00;
   assign bus.page       = page_ff;
   assign bus.sleep_exit = mem_ff[`PMCA_REG_MODE][`PMCA_BIT_SLEEP_EXIT];
   assign bus.bcast_en   = mem_ff[`PMCA_REG_MODE][`PMCA_BIT_BCAST];
   assign bus.analog_regulator_rail_sel   = mem_ff[`PMCA_REG_MODE][`PMCA_BIT_ANALOG_REGULATOR_RAIL_SEL];
   assign bus.shdn_cfg   = mem_ff[`PMCA_REG_SHDN_CFG][`PMCA_SHDN_CFG_LSB+:2];
   assign bus.input_channel_enables   = mem_ff[`PMCA_REG_INPUT_CHANNEL_ENABLES];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_page_switch: assert property (bus.wr && is_page && !bus.clear |=> page_ff == $past(bus.wdata)) // RULE14
      else $error("page selector did not take written value");
   chk_page_default: assert property (bus.clear |=> page_ff == `PMCA_PAGE_CFG) // RULE13
      else $error("page not back to zero after clear");
endmodule // pmca_regs

// ==== rtl/pmca_top.sv ====
// Purpose: Device mode sequencer, control access front end and I2C address select
// Assumes: All pins synchronous to clk; one register access strobe at a time
// Notes:   Long ramp and wake counts are parameters so simulation can shorten them
//
// Operation
// RULE1: Shutdown pin low: lose contents, ignore traffic
// RULE2: Pin falls in active: ramp, power down, shutdown
// RULE3: Ramp config zero: enter shutdown immediately
// RULE4: Host holds pin low at least 1 ms
// RULE5: Pin rise loads defaults, then sleep mode
// RULE6: Sleep-exit cleared: ramp down, sleep, keep registers
// RULE7: Host waits 10 ms, only exit in sleep
// RULE8: Host writes regulator source when leaving sleep
// RULE9: Sleep-exit set: active after 1 ms wake
// RULE10: Host writes settings, enables, then power-up config
// RULE11: Soft reset: immediate shutdown, defaults, self-clearing
// RULE12: Pages of 128 eight-bit registers
// RULE13: Page 0 default; coefficients on pages 2-4
// RULE14: Register 0 of every page selects page
// RULE15: Detect I2C or SPI from shared pins
// RULE16: I2C slave address top bits fixed 10011
// RULE17: Address low bits follow the two straps
// RULE18: Broadcast enable forces address 1001100
// RULE19: Status registers show live block power state
// RULE20: Soft reset bit reads zero; access resumes
`timescale 1ns/1ps
`include "pmca_cfg.svh"
module pmca_top
   import pmca_pkg::*;
#(
   parameter int SHDN_RAMP_CYC  = `PMCA_SHDN_RAMP_CYC,
   parameter int SLEEP_RAMP_CYC = `PMCA_SLEEP_RAMP_CYC,
   parameter int WAKE_CYC       = `PMCA_WAKE_CYC,
   parameter int CNT_W          = 23
)(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       shutdown_n_pin,
   input  wire logic       data_or_select_pin,
   input  wire logic       clock_or_mosi_pin,
   input  wire logic       address_bit0_clock_pin,
   input  wire logic       address_bit1_data_out_pin,
   input  wire logic       acc_valid,
   input  wire logic       acc_write,
   input  wire logic [6:0] acc_addr,
   input  wire logic [7:0] acc_wdata,
   output logic            acc_ack,
   output logic [7:0]      acc_rdata,
   output logic [6:0]      slave_address,
   output logic            proto_is_i2c,
   output logic            proto_is_spi,
   output logic            hw_shutdown,
   output logic            sleep_mode,
   output logic            active_mode,
   output logic            volume_ramp_down,
   output logic            analog_power_en,
   output logic            digital_power_en,
   output logic            regulator_source_sel
);
   pmca_if bus ();

   pmca_mode_e       state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic             acc_ack_ff;
   pmca_byte_t       acc_rdata_ff;
   logic [6:0]       slave_address_ff;
   logic             sel_prev_ff;
   logic             proto_i2c_ff;
   logic             proto_spi_ff;
   logic             vol_ramp_ff;
   logic             power_ff;
   logic             analog_regulator_rail_ff;
   logic             hw_ff;
   logic             sleep_ff;
   logic             active_ff;

   function automatic logic [CNT_W-1:0] cyc_load(input int cycles);
      return CNT_W'(cycles - 1);
   endfunction

   // Nothing is answered once the pin is low or while defaults load
   wire pin_low    = !shutdown_n_pin;
   wire acc_open   = shutdown_n_pin && state_ff != PMCA_HW_SHDN && state_ff != PMCA_LOAD_DEF &&
                     state_ff != PMCA_RAMP_SHDN; // RULE1
   wire acc_take   = acc_valid && acc_open;
   wire cnt_done   = cnt_ff == '0;
   wire ramp_skip  = bus.shdn_cfg == 2'b00;
   wire in_run     = state_ff == PMCA_ACTIVE || state_ff == PMCA_WAKE;

   assign bus.wr     = acc_take && acc_write;
   assign bus.addr   = acc_addr;
   assign bus.wdata  = acc_wdata;
   assign bus.clear  = state_ff == PMCA_HW_SHDN || state_ff == PMCA_LOAD_DEF; // RULE1 RULE5
   assign bus.status0 = (state_ff == PMCA_ACTIVE) ? bus.input_channel_enables : 8'h00; // RULE19
   assign bus.status1 = in_run ? `PMCA_STS1_ACTIVE :
                        (state_ff == PMCA_SLEEP) ? `PMCA_STS1_SLEEP : 8'h00; // RULE19

   pmca_regs u_regs (
      .clk     (clk),
      .reset_n (reset_n),
      .bus     (bus)
   );

   // Pin low outranks everything, then soft reset, then sleep control
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - CNT_W'(1);
      unique case (state_ff)
         PMCA_HW_SHDN: begin
            if (shutdown_n_pin)
               nxt_state = PMCA_LOAD_DEF; // RULE5
         end
         PMCA_LOAD_DEF: begin
            nxt_state = pin_low ? PMCA_HW_SHDN : PMCA_SLEEP; // RULE5
         end
         PMCA_SLEEP: begin
            if (pin_low)
               nxt_state = PMCA_HW_SHDN;
            else if (bus.soft_reset_req)
               nxt_state = PMCA_LOAD_DEF;
            else if (bus.sleep_exit) begin
               nxt_state = PMCA_WAKE; // RULE9
               nxt_cnt   = cyc_load(WAKE_CYC);
            end
         end
         PMCA_WAKE, PMCA_ACTIVE: begin
            if (pin_low && ramp_skip)
               nxt_state = PMCA_HW_SHDN; // RULE3
            else if (pin_low) begin
               nxt_state = PMCA_RAMP_SHDN; // RULE2
               nxt_cnt   = cyc_load(SHDN_RAMP_CYC);
            end else if (bus.soft_reset_req)
               nxt_state = PMCA_LOAD_DEF; // RULE11
            else if (!bus.sleep_exit) begin
               nxt_state = PMCA_RAMP_SLEEP; // RULE6
               nxt_cnt   = cyc_load(SLEEP_RAMP_CYC);
            end else if (state_ff == PMCA_WAKE && cnt_done)
               nxt_state = PMCA_ACTIVE; // RULE9
         end
         PMCA_RAMP_SLEEP: begin
            if (pin_low && ramp_skip)
               nxt_state = PMCA_HW_SHDN; // RULE3
            else if (pin_low) begin
               nxt_state = PMCA_RAMP_SHDN; // RULE2
               nxt_cnt   = cyc_load(SHDN_RAMP_CYC);
            end else if (bus.soft_reset_req)
               nxt_state = PMCA_LOAD_DEF; // RULE11
            else if (cnt_done)
               nxt_state = PMCA_SLEEP; // RULE6
         end
         PMCA_RAMP_SHDN: begin
            if (cnt_done)
               nxt_state = PMCA_HW_SHDN; // RULE2
         end
         default: begin
            nxt_state = PMCA_HW_SHDN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= PMCA_HW_SHDN;
         cnt_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // Ramp flag covers both ways down; power rails on while running or ramping down
   wire nxt_vol_ramp = nxt_state == PMCA_RAMP_SHDN || nxt_state == PMCA_RAMP_SLEEP; // RULE2 RULE6
   wire nxt_power    = nxt_state == PMCA_WAKE || nxt_state == PMCA_ACTIVE || nxt_vol_ramp;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         vol_ramp_ff <= 1'b0;
         power_ff    <= 1'b0;
         analog_regulator_rail_ff     <= 1'b0;
         hw_ff       <= 1'b1;
         sleep_ff    <= 1'b0;
         active_ff   <= 1'b0;
      end else begin
         vol_ramp_ff <= nxt_vol_ramp;
         power_ff    <= nxt_power;
         analog_regulator_rail_ff     <= bus.analog_regulator_rail_sel;
         hw_ff       <= nxt_state == PMCA_HW_SHDN;
         sleep_ff    <= nxt_state == PMCA_SLEEP;
         active_ff   <= nxt_state == PMCA_ACTIVE;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc_ack_ff   <= 1'b0;
         acc_rdata_ff <= 8'h00;
      end else begin
         acc_ack_ff   <= acc_take; // RULE20
         acc_rdata_ff <= (acc_take && !acc_write) ? bus.rdata : 8'h00;
      end
   end

   // Straps are static, so they are followed rather than latched
   wire [6:0] nxt_slave_address = bus.bcast_en ? `PMCA_ADDR_BCAST : // RULE18
                                  {`PMCA_ADDR_FIXED, address_bit1_data_out_pin, address_bit0_clock_pin}; // RULE16 RULE17

   // First select/data fall decides: clock-line high means an I2C start
   wire sel_fall = sel_prev_ff && !data_or_select_pin;

   always_ff @(posedge clk) begin
      if (!reset_n || !shutdown_n_pin) begin
         slave_address_ff <= 7'h00;
         sel_prev_ff      <= 1'b1;
         proto_i2c_ff     <= 1'b0;
         proto_spi_ff     <= 1'b0;
      end else begin
         slave_address_ff <= nxt_slave_address;
         sel_prev_ff      <= data_or_select_pin;
         if (sel_fall && !proto_i2c_ff && !proto_spi_ff) begin
            proto_i2c_ff <= clock_or_mosi_pin; // RULE15
            proto_spi_ff <= !clock_or_mosi_pin; // RULE15
         end
      end
   end

   assign acc_ack              = acc_ack_ff;
   assign acc_rdata            = acc_rdata_ff;
   assign slave_address        = slave_address_ff;
   assign proto_is_i2c         = proto_i2c_ff;
   assign proto_is_spi         = proto_spi_ff;
   assign hw_shutdown          = hw_ff;
   assign sleep_mode           = sleep_ff;
   assign active_mode          = active_ff;
   assign volume_ramp_down     = vol_ramp_ff;
   assign analog_power_en      = power_ff;
   assign digital_power_en     = power_ff;
   assign regulator_source_sel = analog_regulator_rail_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_shdn_no_answer: assert property (pin_low |=> !acc_ack_ff) // RULE1
      else $error("access answered while shutdown pin low");
   chk_ramp_start: assert property (state_ff == PMCA_ACTIVE && pin_low && !ramp_skip
                                    |=> state_ff == PMCA_RAMP_SHDN ##1 vol_ramp_ff) // RULE2
      else $error("shutdown ramp not started");
   chk_ramp_end: assert property (state_ff == PMCA_RAMP_SHDN && cnt_done |=> hw_shutdown) // RULE2
      else $error("ramp did not end in shutdown");
   chk_ramp_skip: assert property (state_ff == PMCA_ACTIVE && pin_low && ramp_skip
                                   |=> state_ff == PMCA_HW_SHDN ##1 !power_ff) // RULE3
      else $error("zero ramp config did not shut down at once");
   chk_load_sleep: assert property (state_ff == PMCA_LOAD_DEF && shutdown_n_pin |=> sleep_mode) // RULE5
      else $error("defaults load not followed by sleep");
   chk_sleep_enter: assert property (state_ff == PMCA_ACTIVE && shutdown_n_pin && !bus.sleep_exit &&
                                     !bus.soft_reset_req |=> state_ff == PMCA_RAMP_SLEEP) // RULE6
      else $error("sleep request not honoured");
   chk_wake_enter: assert property (sleep_mode && shutdown_n_pin && !bus.soft_reset_req && bus.sleep_exit
                                    |=> state_ff == PMCA_WAKE ##1 power_ff) // RULE9
      else $error("sleep exit did not start wake");
   chk_soft_reset: assert property (bus.soft_reset_req && shutdown_n_pin && state_ff != PMCA_RAMP_SHDN
                                    |=> state_ff == PMCA_LOAD_DEF ##1 sleep_mode || pin_low) // RULE11
      else $error("soft reset did not restore defaults");
   chk_bcast_addr: assert property (shutdown_n_pin && bus.bcast_en |=> slave_address_ff == `PMCA_ADDR_BCAST) // RULE18
      else $error("broadcast address not applied");
   chk_strap_addr: assert property (shutdown_n_pin && !bus.bcast_en |=>
                                    slave_address_ff[1] == $past(address_bit1_data_out_pin) &&
                                    slave_address_ff[0] == $past(address_bit0_clock_pin)) // RULE17
      else $error("strap address bits not followed");
endmodule // pmca_top

// ==== verif/pmca_host.sv ====
// Purpose: Host processor model driving the control access port and pins
// Assumes: Requests change at the falling edge and are held over one rising edge
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module pmca_host (
   input  wire logic       clk,
   input  wire logic       acc_ack,
   input  wire logic [7:0] acc_rdata,
   output logic            acc_valid,
   output logic            acc_write,
   output logic [6:0]      acc_addr,
   output logic [7:0]      acc_wdata,
   output logic            shutdown_n_pin,
   output logic            data_or_select_pin,
   output logic            clock_or_mosi_pin,
   output logic            address_bit0_clock_pin,
   output logic            address_bit1_data_out_pin
);
   initial begin
      acc_valid                 = 1'b0;
      acc_write                 = 1'b0;
      acc_addr                  = 7'h00;
      acc_wdata                 = 8'h00;
      shutdown_n_pin            = 1'b1;
      data_or_select_pin        = 1'b1;
      clock_or_mosi_pin         = 1'b1;
      address_bit0_clock_pin    = 1'b0;
      address_bit1_data_out_pin = 1'b0;
   end
   // One protocol only: the host uses the I2C start pattern and never SPI
   task automatic set_pins(input logic shdn_n, input logic dsel, input logic [1:0] straps);
      @(negedge clk);
      shutdown_n_pin            = shdn_n;
      data_or_select_pin        = dsel;
      address_bit1_data_out_pin = straps[1];
      address_bit0_clock_pin    = straps[0];
   endtask
   // Caller keeps sleep traffic to the exit write and orders enables before power-up
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                         output logic ack, output logic [7:0] rd);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_write = wr;
      acc_addr  = a;
      acc_wdata = d;
      @(negedge clk);
      ack       = acc_ack;
      rd        = acc_rdata;
      acc_valid = 1'b0;
      acc_addr  = ~a;
      acc_wdata = ~d;
   endtask
endmodule // pmca_host

// ==== verif/power_mode_and_control_access_test.sv ====
// Purpose: Self-checking bench for the mode sequencer and paged access port
// Assumes: Short ramp and wake counts set through parameters
// Notes:   Register model only predicts places the bench has written or knows
`timescale 1ns/1ps
module power_mode_and_control_access_test;
   localparam int RAMP = 20;
   localparam int WAKE = 10;
   logic       clk;
   logic       reset_n;
   logic       acc_valid, acc_write, acc_ack, shutdown_n_pin, data_or_select_pin, clock_or_mosi_pin;
   logic       address_bit0_clock_pin, address_bit1_data_out_pin, proto_is_i2c, proto_is_spi;
   logic       hw_shutdown, sleep_mode, active_mode, volume_ramp_down, analog_power_en;
   logic       digital_power_en, regulator_source_sel;
   logic [6:0] acc_addr, slave_address;
   logic [7:0] acc_wdata, acc_rdata, v;
   int         n_mismatch, n_tests, page, n, r;
   int         mem[int];
   logic [1:0] st;
   pmca_top #(.SHDN_RAMP_CYC(RAMP), .SLEEP_RAMP_CYC(RAMP), .WAKE_CYC(WAKE), .CNT_W(23)) i_pmca_top (
      .clk(clk), .reset_n(reset_n), .shutdown_n_pin(shutdown_n_pin), .data_or_select_pin(data_or_select_pin),
      .clock_or_mosi_pin(clock_or_mosi_pin), .address_bit0_clock_pin(address_bit0_clock_pin),
      .address_bit1_data_out_pin(address_bit1_data_out_pin), .acc_valid(acc_valid), .acc_write(acc_write),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
      .slave_address(slave_address), .proto_is_i2c(proto_is_i2c), .proto_is_spi(proto_is_spi),
      .hw_shutdown(hw_shutdown), .sleep_mode(sleep_mode), .active_mode(active_mode),
      .volume_ramp_down(volume_ramp_down), .analog_power_en(analog_power_en),
      .digital_power_en(digital_power_en), .regulator_source_sel(regulator_source_sel));
   pmca_host i_pmca_host (
      .clk(clk), .acc_ack(acc_ack), .acc_rdata(acc_rdata), .acc_valid(acc_valid), .acc_write(acc_write),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .shutdown_n_pin(shutdown_n_pin),
      .data_or_select_pin(data_or_select_pin), .clock_or_mosi_pin(clock_or_mosi_pin),
      .address_bit0_clock_pin(address_bit0_clock_pin), .address_bit1_data_out_pin(address_bit1_data_out_pin));
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Reads of 0x76 and 0x77 are only made in active mode
   function automatic int mread(input int a);
      if (a == 0) return page;
      if (a == 1 || !(page inside {0, 2, 3, 4})) return 0;
      if (page == 0 && a == 8'h76) return mem[8'h73];
      if (page == 0 && a == 8'h77) return 8'hC0;
      if (mem.exists(page * 128 + a)) return mem[page * 128 + a];
      return (page == 0 && a == 5) ? 8'h04 : 0;
   endfunction
   function automatic void mwrite(input int a, input int d);
      if (a == 0) page = d;
      else if (page == 0 && a == 1) begin
         if (d[0]) begin
            mem.delete();
            page = 0;
         end
      end else if (page inside {0, 2, 3, 4} && !(page == 0 && a inside {8'h76, 8'h77})) mem[page * 128 + a] = d;
   endfunction
   task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d, input logic exp_ack);
      logic       ack;
      logic [7:0] rd;
      i_pmca_host.access(wr, a, d, ack, rd);
      check("acc_ack", {7'h00, ack}, {7'h00, exp_ack});
      if (exp_ack && !wr) check("acc_rdata", rd, 8'(mread(a)));
      if (exp_ack && wr) mwrite(a, d);
   endtask
   // Counts cycles until the chosen mode shows, and ramp cycles seen on the way
   task automatic wait_on(input int sel, input int lim);
      n = 0;
      r = 0;
      while (!(sel == 0 ? active_mode === 1'b1 : sel == 1 ? sleep_mode === 1'b1 : hw_shutdown === 1'b1)) begin
         @(negedge clk);
         n++;
         if (volume_ramp_down === 1'b1) r++;
         if (n > lim) begin
            n_mismatch++;
            $display("[ERR] mode wait %0d expected reached seen timeout", sel);
            conclude();
         end
      end
   endtask
   task automatic wake();
      repeat (10 * WAKE) @(negedge clk);
      acc(1'b1, 7'h02, 8'h81, 1'b1);
      wait_on(0, 4 * WAKE);
      check("power_en", {6'h00, analog_power_en, digital_power_en}, 8'h03);
      check("wake_len", 8'(n inside {[WAKE - 2 : WAKE + 2]}), 8'h01);
      check("regulator_source_sel", {7'h00, regulator_source_sel}, 8'h01);
   endtask
   initial begin
      void'($urandom(32'h859A));
      reset_n = 1'b0;
      page = 0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      check("sleep_mode", {7'h00, sleep_mode}, 8'h01);
      for (int s = 0; s < 4; s++) begin
         st = 2'(s);
         i_pmca_host.set_pins(1'b1, 1'b1, st);
         repeat (2) @(negedge clk);
         check("slave_address", {1'b0, slave_address}, {1'b0, 5'h13, st});
      end
      i_pmca_host.set_pins(1'b1, 1'b0, st);
      repeat (2) @(negedge clk);
      check("proto_is_i2c", {6'h00, proto_is_i2c, proto_is_spi}, 8'h02);
      i_pmca_host.set_pins(1'b1, 1'b1, st);
      wake();
      acc(1'b1, 7'h02, 8'h85, 1'b1);
      repeat (2) @(negedge clk);
      check("slave_bcast", {1'b0, slave_address}, 8'h4C);
      acc(1'b1, 7'h02, 8'h81, 1'b1);
      for (int p = 0; p < 6; p++) begin
         v = 8'($urandom);
         acc(1'b1, 7'h00, 8'(p), 1'b1);
         acc(1'b1, 7'h7F, v, 1'b1);
         acc(1'b0, 7'h7F, 8'h00, 1'b1);
         acc(1'b0, 7'h00, 8'h00, 1'b1);
      end
      acc(1'b1, 7'h00, 8'h00, 1'b1);
      v = 8'($urandom);
      acc(1'b1, 7'h73, v, 1'b1);
      acc(1'b1, 7'h77, 8'h00, 1'b1);
      acc(1'b0, 7'h76, 8'h00, 1'b1);
      acc(1'b0, 7'h77, 8'h00, 1'b1);
      acc(1'b1, 7'h02, 8'h80, 1'b1);
      wait_on(1, 4 * RAMP);
      check("sleep_ramp", 8'(r inside {[RAMP - 2 : RAMP + 2]}), 8'h01);
      wake();
      acc(1'b0, 7'h73, 8'h00, 1'b1);
      acc(1'b1, 7'h05, 8'h00, 1'b1);
      acc(1'b1, 7'h00, 8'h02, 1'b1);
      acc(1'b1, 7'h10, 8'h5A, 1'b1);
      acc(1'b1, 7'h00, 8'h00, 1'b1);
      acc(1'b1, 7'h01, 8'h01, 1'b1);
      wait_on(1, 8);
      check("reset_fast", 8'(n <= 3), 8'h01);
      wake();
      acc(1'b0, 7'h01, 8'h00, 1'b1);
      acc(1'b0, 7'h00, 8'h00, 1'b1);
      acc(1'b0, 7'h05, 8'h00, 1'b1);
      acc(1'b1, 7'h00, 8'h02, 1'b1);
      acc(1'b0, 7'h10, 8'h00, 1'b1);
      acc(1'b1, 7'h00, 8'h00, 1'b1);
      acc(1'b1, 7'h73, 8'h3C, 1'b1);
      i_pmca_host.set_pins(1'b0, 1'b1, st);
      wait_on(2, 4 * RAMP);
      check("shdn_ramp", 8'(r inside {[RAMP - 2 : RAMP + 2]}), 8'h01);
      check("power_off", {6'h00, analog_power_en, digital_power_en}, 8'h00);
      acc(1'b0, 7'h00, 8'h00, 1'b0);
      check("slave_off", {1'b0, slave_address}, 8'h00);
      repeat (WAKE) @(negedge clk);
      mem.delete();
      page = 0;
      i_pmca_host.set_pins(1'b1, 1'b1, st);
      wait_on(1, 8);
      wake();
      acc(1'b0, 7'h73, 8'h00, 1'b1);
      acc(1'b1, 7'h05, 8'h00, 1'b1);
      i_pmca_host.set_pins(1'b0, 1'b1, st);
      wait_on(2, 8);
      check("shdn_now", 8'(r == 0 && n <= 2), 8'h01);
      conclude();
   end
endmodule // power_mode_and_control_access_test
